// file: hw/egp_port.sv
// Eight-pin GPIO port whose pins are taken over by the external memory bus.
// Assumes a plain register port with read data one cycle after the strobe,
// and a board-level pad that resolves pin_out and pin_oe into a wire.
//
// Operation
// RULE1: One port of eight pins, each usable as input or output.
// RULE2: Direction 0 drives pin from latch; 1 makes it an input read back.
// RULE3: Every reset leaves all eight pins as inputs.
// RULE4: Clearing the bus disable bit makes all pins bus control outputs.
// RULE5: In bus mode direction bits are ignored and every pin drives.
// RULE6: One shared bit enables all weak pull-ups; clearing it disables them.
// RULE7: A pin configured as output has its pull-up switched off.
// RULE8: Every reset leaves the pull-ups disabled.
// RULE9: Bus pins 0..3: address latch enable, output enable, write low, write high.
// RULE10: Bus pins 4..7: byte address zero, chip enable, lower, upper byte enable.
// RULE11: Bus control function takes priority over general I/O use.
// RULE12: Writing either the pins or latch register updates the latches.
// RULE13: On the small variant port bits are unimplemented and read zero.
// RULE14: Pin input levels are synchronised before software reads them.
`timescale 1ns/1ps
`include "egp_consts.svh"

module egp_port #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic clk, // System clock, 200 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire egp_pkg::egp_addr_t addr, // Register address
    input wire egp_pkg::egp_byte_t wdata, // Register write data
    input wire logic wr_en, // Register write strobe
    input wire logic rd_en, // Register read strobe
    output egp_pkg::egp_byte_t rdata, // Read data, cycle after rd_en
    input wire egp_pkg::egp_byte_t pin_in, // Pin levels from pads
    output egp_pkg::egp_byte_t pin_out, // Pin drive levels
    output egp_pkg::egp_byte_t pin_oe, // Pin drive enables
    output egp_pkg::egp_byte_t pin_pullup, // Weak pull-up enables
    output logic ext_bus_active, // Pins owned by external bus
    input wire logic bus_addr_latch_en, // Bus address latch enable
    input wire logic bus_output_enable_n, // Bus output enable, active low
    input wire logic bus_write_low_strobe, // Bus low byte write strobe
    input wire logic bus_write_high_strobe, // Bus high byte write strobe
    input wire logic bus_byte_address_zero, // Bus byte address 0
    input wire logic bus_chip_enable, // Bus chip enable
    input wire logic bus_lower_byte_enable, // Bus lower byte enable
    input wire logic bus_upper_byte_enable // Bus upper byte enable
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam logic IMPLEMENTED = ~SMALL_VARIANT;

    egp_pkg::egp_byte_t ninth_port_latch;
    egp_pkg::egp_byte_t ninth_port_direction;
    logic ninth_port_pullup_enable;
    logic ext_bus_disable;

    egp_pkg::egp_byte_t next_latch;
    egp_pkg::egp_byte_t next_direction;
    logic next_pullup_enable;
    logic next_ext_bus_disable;

    egp_pkg::egp_byte_t next_rdata;
    egp_pkg::egp_byte_t read_value;

    egp_pkg::egp_byte_t next_pin_out;
    egp_pkg::egp_byte_t next_pin_oe;
    egp_pkg::egp_byte_t next_pin_pullup;
    logic next_ext_bus_active;

    egp_pkg::egp_byte_t pins_sync;
    egp_pkg::egp_byte_t bus_level;
    egp_pkg::egp_byte_t mux_drive;
    egp_pkg::egp_byte_t mux_drive_en;
    egp_pkg::egp_byte_t mux_pullup;
    egp_pkg::egp_mode_e mode;

    logic wr_pins;
    logic wr_latch;
    logic wr_direction;
    logic wr_seventh;
    logic wr_mem_bus;

    // ****************************************
    // Write decode
    // ****************************************
    always_comb begin
        wr_pins = 1'b0;
        wr_latch = 1'b0;
        wr_direction = 1'b0;
        wr_seventh = 1'b0;
        wr_mem_bus = 1'b0;
        if (wr_en) begin
            if (addr == `EGP_OFS_PINS) begin
                wr_pins = 1'b1;
            end else if (addr == `EGP_OFS_LATCH) begin
                wr_latch = 1'b1;
            end else if (addr == `EGP_OFS_DIRECTION) begin
                wr_direction = 1'b1;
            end else if (addr == `EGP_OFS_SEVENTH_PORT) begin
                wr_seventh = 1'b1;
            end else if (addr == `EGP_OFS_MEM_BUS_CTL) begin
                wr_mem_bus = 1'b1;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_comb begin
        next_latch = ninth_port_latch;
        next_direction = ninth_port_direction;
        next_pullup_enable = ninth_port_pullup_enable;
        next_ext_bus_disable = ext_bus_disable;
        if (srst) begin
            next_latch = `EGP_RST_LATCH;
            next_direction = `EGP_RST_DIRECTION; // RULE3
            next_pullup_enable = `EGP_RST_PULLUP_ENABLE; // RULE8
            next_ext_bus_disable = `EGP_RST_EXT_BUS_DISABLE; // RULE3
        end else begin
            if (IMPLEMENTED && (wr_pins || wr_latch)) begin
                next_latch = wdata; // RULE12
            end
            if (IMPLEMENTED && wr_direction) begin
                next_direction = wdata; // RULE1
            end
            if (IMPLEMENTED && wr_seventh) begin
                next_pullup_enable = wdata[`EGP_BIT_PULLUP_ENABLE]; // RULE6
            end
            if (wr_mem_bus) begin
                next_ext_bus_disable = wdata[`EGP_BIT_EXT_BUS_DISABLE]; // RULE4
            end
        end
    end

    always_ff @(posedge clk) begin
        ninth_port_latch <= next_latch;
        ninth_port_direction <= next_direction;
        ninth_port_pullup_enable <= next_pullup_enable;
        ext_bus_disable <= next_ext_bus_disable;
    end

    // ****************************************
    // Input synchroniser
    // ****************************************
    egp_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in(pin_in),
        .sync_out(pins_sync) // RULE14
    );

    // ****************************************
    // External bus pin assignment
    // ****************************************
    always_comb begin
        bus_level = `EGP_READ_ZERO;
        bus_level[`EGP_PIN_ADDR_LATCH_EN] = bus_addr_latch_en; // RULE9
        bus_level[`EGP_PIN_OUTPUT_ENABLE] = bus_output_enable_n; // RULE9
        bus_level[`EGP_PIN_WRITE_LOW] = bus_write_low_strobe; // RULE9
        bus_level[`EGP_PIN_WRITE_HIGH] = bus_write_high_strobe; // RULE9
        bus_level[`EGP_PIN_BYTE_ADDR_ZERO] = bus_byte_address_zero; // RULE10
        bus_level[`EGP_PIN_CHIP_ENABLE] = bus_chip_enable; // RULE10
        bus_level[`EGP_PIN_LOWER_BYTE] = bus_lower_byte_enable; // RULE10
        bus_level[`EGP_PIN_UPPER_BYTE] = bus_upper_byte_enable; // RULE10
    end

    // Clearing the disable bit hands every pin to the bus
    always_comb begin
        if (ext_bus_disable) begin
            mode = egp_pkg::egp_mode_gpio;
        end else begin
            mode = egp_pkg::egp_mode_bus; // RULE4
        end
    end

    // ****************************************
    // Pin multiplexer
    // ****************************************
    egp_pin_mux #(
        .WIDTH(8)
    ) u_pin_mux (
        .implemented(IMPLEMENTED),
        .mode(mode),
        .latch(ninth_port_latch),
        .direction(ninth_port_direction),
        .bus_level(bus_level),
        .pullup_enable(ninth_port_pullup_enable),
        .drive(mux_drive),
        .drive_en(mux_drive_en),
        .pull_on(mux_pullup)
    );

    // ****************************************
    // Pin output registers
    // ****************************************
    always_comb begin
        if (srst) begin
            next_pin_out = `EGP_READ_ZERO;
            next_pin_oe = `EGP_READ_ZERO; // RULE3
            next_pin_pullup = `EGP_READ_ZERO; // RULE8
            next_ext_bus_active = 1'b0;
        end else begin
            next_pin_out = mux_drive;
            next_pin_oe = mux_drive_en; // RULE5
            next_pin_pullup = mux_pullup; // RULE7
            next_ext_bus_active = IMPLEMENTED && (mode == egp_pkg::egp_mode_bus);
        end
    end

    always_ff @(posedge clk) begin
        pin_out <= next_pin_out;
        pin_oe <= next_pin_oe;
        pin_pullup <= next_pin_pullup;
        ext_bus_active <= next_ext_bus_active;
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        read_value = `EGP_READ_ZERO;
        if (addr == `EGP_OFS_PINS) begin
            read_value = pins_sync; // RULE2
        end else if (addr == `EGP_OFS_LATCH) begin
            read_value = ninth_port_latch;
        end else if (addr == `EGP_OFS_DIRECTION) begin
            read_value = ninth_port_direction;
        end else if (addr == `EGP_OFS_SEVENTH_PORT) begin
            read_value[`EGP_BIT_PULLUP_ENABLE] = ninth_port_pullup_enable;
        end else if (addr == `EGP_OFS_MEM_BUS_CTL) begin
            read_value[`EGP_BIT_EXT_BUS_DISABLE] = ext_bus_disable;
        end else if (addr == `EGP_OFS_DRIVE_STATUS) begin
            read_value = pin_oe;
        end
        // Port bits of the small variant read as zero
        if (!IMPLEMENTED && addr != `EGP_OFS_MEM_BUS_CTL) begin
            read_value = `EGP_READ_ZERO; // RULE13
        end
    end

    // Data stands only in the cycle after the strobe
    always_comb begin
        next_rdata = `EGP_RST_READ_DATA;
        if (!srst && rd_en) begin
            next_rdata = read_value;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= next_rdata;
    end

endmodule // egp_port

// file: hw/egp_consts.svh
// Constants for the external-bus control GPIO port: offsets, bit positions,
// reset values and the external bus pin assignment.
// Assumes a 4-bit register address and 8-bit register data.
`ifndef EGP_CONSTS_SVH
`define EGP_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define EGP_OFS_PINS 4'h0
`define EGP_OFS_LATCH 4'h1
`define EGP_OFS_DIRECTION 4'h2
`define EGP_OFS_SEVENTH_PORT 4'h3
`define EGP_OFS_MEM_BUS_CTL 4'h4
`define EGP_OFS_DRIVE_STATUS 4'h5

// ****************************************
// Field positions
// ****************************************
`define EGP_BIT_PULLUP_ENABLE 5
`define EGP_BIT_EXT_BUS_DISABLE 7

// ****************************************
// Reset values
// ****************************************
`define EGP_RST_LATCH 8'h00
`define EGP_RST_DIRECTION 8'hff
`define EGP_RST_PULLUP_ENABLE 1'b0
`define EGP_RST_EXT_BUS_DISABLE 1'b1
`define EGP_RST_READ_DATA 8'h00
`define EGP_READ_ZERO 8'h00

// ****************************************
// External bus pin assignment
// ****************************************
`define EGP_PIN_ADDR_LATCH_EN 0
`define EGP_PIN_OUTPUT_ENABLE 1
`define EGP_PIN_WRITE_LOW 2
`define EGP_PIN_WRITE_HIGH 3
`define EGP_PIN_BYTE_ADDR_ZERO 4
`define EGP_PIN_CHIP_ENABLE 5
`define EGP_PIN_LOWER_BYTE 6
`define EGP_PIN_UPPER_BYTE 7

`endif

// file: hw/egp_pkg.sv
// Types shared by the external-bus control GPIO port.
// Assumes nothing beyond a SystemVerilog compiler.
package egp_pkg;

    typedef logic [7:0] egp_byte_t;
    typedef logic [3:0] egp_addr_t;

    // Who owns the eight pins
    typedef enum logic {
        egp_mode_gpio,
        egp_mode_bus
    } egp_mode_e;

endpackage

// file: hw/egp_sync.sv
// Two-flop synchroniser for the eight pin input levels.
// Assumes the pin levels are asynchronous to clk.
`timescale 1ns/1ps

module egp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [WIDTH-1:0] async_in, // Raw pin levels
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                next_stage1[i] = srst ? 1'b0 : async_in[i];
                next_sync_out[i] = srst ? 1'b0 : stage1[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        stage1 <= next_stage1;
        sync_out <= next_sync_out;
    end

endmodule // egp_sync

// file: hw/egp_pin_mux.sv
// Per-pin selection of drive level, output enable and weak pull-up.
// Assumes all inputs except bus_level are registered state of the port; purely combinational.
`timescale 1ns/1ps

module egp_pin_mux #(
    parameter int WIDTH = 8
) (
    input wire logic implemented, // Port exists on this variant
    input wire egp_pkg::egp_mode_e mode, // Pin owner
    input wire logic [WIDTH-1:0] latch, // Output data latches
    input wire logic [WIDTH-1:0] direction, // 1 = input, 0 = output
    input wire logic [WIDTH-1:0] bus_level, // External bus control levels
    input wire logic pullup_enable, // Shared pull-up control
    output logic [WIDTH-1:0] drive, // Level to drive
    output logic [WIDTH-1:0] drive_en, // Pin is driven
    output logic [WIDTH-1:0] pull_on // Weak pull-up on
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            always_comb begin
                drive[i] = 1'b0;
                drive_en[i] = 1'b0;
                if (implemented) begin
                    if (mode == egp_pkg::egp_mode_bus) begin
                        drive[i] = bus_level[i]; // RULE11
                        drive_en[i] = 1'b1; // RULE5
                    end else begin
                        drive[i] = latch[i]; // RULE2
                        drive_en[i] = ~direction[i]; // RULE2
                    end
                end
                pull_on[i] = implemented & pullup_enable & ~drive_en[i]; // RULE7
            end
        end
    endgenerate

endmodule // egp_pin_mux

// file: sim/egp_port_assertions.sv
// Concurrent checks on the ports of egp_port.
// Assumes SMALL_VARIANT = 0 and the bind below.
`timescale 1ns/1ps
`include "egp_consts.svh"

module egp_port_chk (
    input wire logic clk, // Clock
    input wire logic srst, // Reset
    input wire egp_pkg::egp_addr_t addr, // Address
    input wire egp_pkg::egp_byte_t wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    input wire egp_pkg::egp_byte_t rdata, // Read data
    input wire egp_pkg::egp_byte_t pin_out, // Drive level
    input wire egp_pkg::egp_byte_t pin_oe, // Drive enable
    input wire egp_pkg::egp_byte_t pin_pullup, // Pull-ups
    input wire logic ext_bus_active // Bus mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    reset_idle_a: assert property ($fell(srst) |-> pin_oe == 8'h00 && pin_pullup == 8'h00 && !ext_bus_active)
        else $error("outputs not idle after reset");
    bus_drive_a: assert property (ext_bus_active |-> pin_oe == 8'hff && pin_pullup == 8'h00)
        else $error("bus mode pins not all driven");
    bus_entry_a: assert property (wr_en && addr == `EGP_OFS_MEM_BUS_CTL && !wdata[7] |=> ##1 ext_bus_active)
        else $error("bus mode not entered");
    dir_drive_a: assert property (wr_en && addr == `EGP_OFS_DIRECTION ##2 !ext_bus_active |-> pin_oe == ~$past(wdata, 2))
        else $error("drive enable does not follow direction");
    latch_drive_a: assert property (wr_en && addr <= `EGP_OFS_LATCH ##2 !ext_bus_active
        |-> (pin_out & pin_oe) == ($past(wdata, 2) & pin_oe))
        else $error("drive level does not follow latch");
    pullup_ctl_a: assert property (wr_en && addr == `EGP_OFS_SEVENTH_PORT ##2 !ext_bus_active
        |-> pin_pullup == ($past(wdata[5], 2) ? ~pin_oe : 8'h00))
        else $error("pull-up enable wrong");
    pullup_out_a: assert property ((pin_pullup & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    rd_idle_a: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule // egp_port_chk

bind egp_port egp_port_chk i_egp_port_chk (.clk, .srst, .addr, .wdata, .wr_en, .rd_en, .rdata, .pin_out, .pin_oe,
    .pin_pullup, .ext_bus_active);

// file: sim/egp_pad_model.sv
// Board pad model: resolves device drive, board drive and pull-ups.
// Assumes no contention is commanded by the bench.
`timescale 1ns/1ps

module egp_pad_model (
    input wire logic clk, // Clock
    input wire egp_pkg::egp_byte_t pin_out, // Device level
    input wire egp_pkg::egp_byte_t pin_oe, // Device enable
    input wire egp_pkg::egp_byte_t pin_pullup, // Pull-ups
    input wire egp_pkg::egp_byte_t ext_drv, // Board level
    input wire egp_pkg::egp_byte_t ext_en, // Board enable
    output egp_pkg::egp_byte_t pin_in // Pin level
);
    egp_pkg::egp_byte_t last = 8'h00;
    always_ff @(posedge clk) begin
        last <= pin_in;
    end
    // Floating pins toggle so no stale level passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_drv[i];
            else if (pin_pullup[i]) pin_in[i] = 1'b1;
            else pin_in[i] = ~last[i];
        end
    end
endmodule // egp_pad_model

// file: sim/egp_port_tb_top.sv
// Self-checking bench for egp_port against an integer model.
// Assumes egp_pad_model on the pins and the bound checker.
`timescale 1ns/1ps
`include "egp_consts.svh"

module egp_port_tb_top;
    logic clk, srst, wr_en, rd_en, ext_bus_active;
    egp_pkg::egp_addr_t addr;
    egp_pkg::egp_byte_t wdata, rdata, pin_in, pin_out, pin_oe, pin_pullup, ext_drv, ext_en, bus_v, exp_bus;
    logic bus_addr_latch_en, bus_output_enable_n, bus_write_low_strobe, bus_write_high_strobe;
    logic bus_byte_address_zero, bus_chip_enable, bus_lower_byte_enable, bus_upper_byte_enable;
    logic [15:0] lfsr;
    int n_fail, cmp_count, m_lat, m_dir, m_pu, m_drv;
    egp_pkg::egp_byte_t rst_v[5] = '{8'h00, 8'hff, 8'h00, 8'h80, 8'h00};
    egp_pkg::egp_byte_t bq[$];
    assign {bus_upper_byte_enable, bus_lower_byte_enable, bus_chip_enable, bus_byte_address_zero,
        bus_write_high_strobe, bus_write_low_strobe, bus_output_enable_n, bus_addr_latch_en} = bus_v;

    egp_port i_egp_port (.clk, .srst, .addr, .wdata, .wr_en, .rd_en, .rdata, .pin_in, .pin_out, .pin_oe,
        .pin_pullup, .ext_bus_active, .bus_addr_latch_en, .bus_output_enable_n, .bus_write_low_strobe,
        .bus_write_high_strobe, .bus_byte_address_zero, .bus_chip_enable, .bus_lower_byte_enable,
        .bus_upper_byte_enable);
    egp_pad_model i_egp_pad_model (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_drv, .ext_en, .pin_in);

    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string what, input egp_pkg::egp_byte_t exp, input egp_pkg::egp_byte_t got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input egp_pkg::egp_addr_t a, input egp_pkg::egp_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input egp_pkg::egp_addr_t a, input egp_pkg::egp_byte_t exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pins_chk;
        chk("pin_oe", 8'(~m_dir), pin_oe);
        chk("pin_out", 8'(m_lat & ~m_dir), pin_out & pin_oe);
        chk("pin_pullup", 8'(m_pu ? m_dir : 0), pin_pullup);
        chk("ext_bus_active", 8'h00, {7'h00, ext_bus_active});
    endtask
    task automatic do_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        m_lat = 0;
        m_dir = 255;
        m_pu = 0;
        tick(2);
    endtask
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        test_done;
    end
    initial begin
        {wr_en, rd_en, addr, wdata, ext_drv, ext_en, bus_v} = '0;
        srst = 1'b1;
        lfsr = 16'hb24a;
        do_reset;
        pins_chk;
        for (int a = 1; a < 6; a++) rd(4'(a), rst_v[a-1], "reset value");
        rd(4'h9, 8'h00, "unmapped");
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            m_dir = lfsr[7:0];
            m_lat = lfsr[15:8];
            m_drv = lfsr[11:4];
            m_pu = lfsr[2];
            @(posedge clk);
            ext_en <= 8'(m_dir);
            ext_drv <= 8'(m_drv);
            wr(`EGP_OFS_DIRECTION, 8'(m_dir));
            wr(4'(i % 2), 8'(m_lat));
            wr(`EGP_OFS_SEVENTH_PORT, 8'(m_pu ? 8'hff : 8'hdf));
            tick(2);
            pins_chk;
            rd(`EGP_OFS_PINS, 8'((m_lat & ~m_dir) | (m_drv & m_dir)), "pins");
            rd(`EGP_OFS_SEVENTH_PORT, 8'(m_pu << 5), "pull-up bit");
            rd(`EGP_OFS_DIRECTION, 8'(m_dir), "direction");
            rd(`EGP_OFS_DRIVE_STATUS, 8'(~m_dir), "drive status");
        end
        @(posedge clk);
        ext_en <= 8'h00;
        wr(`EGP_OFS_SEVENTH_PORT, 8'h20);
        wr(`EGP_OFS_MEM_BUS_CTL, 8'h00);
        wr(`EGP_OFS_DIRECTION, 8'hff);
        wr(`EGP_OFS_LATCH, 8'h00);
        m_dir = 255;
        m_lat = 0;
        m_pu = 1;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            lfsr = lfsr_next(lfsr);
            bus_v <= lfsr[7:0];
            bq.push_back(lfsr[7:0]);
            #1;
            if (bq.size() > 1) begin
                exp_bus = bq.pop_front();
                chk("bus pin_out", exp_bus, pin_out);
                chk("bus pin_oe", 8'hff, pin_oe);
                chk("bus pin_pullup", 8'h00, pin_pullup);
                chk("bus ext_bus_active", 8'h01, {7'h00, ext_bus_active});
            end
        end
        wr(`EGP_OFS_MEM_BUS_CTL, 8'h80);
        tick(2);
        pins_chk;
        rd(`EGP_OFS_PINS, 8'hff, "pulled pins");
        do_reset;
        pins_chk;
        rd(`EGP_OFS_SEVENTH_PORT, 8'h00, "pull-up after reset");
        test_done;
    end
endmodule // egp_port_tb_top
